// file: include/tbu_pkg.sv
// Purpose: shared constants and types of the tx buffer unpacker
// Assumes: one core clock, apb register access, 32-bit host words
// Notes:   command field positions, register offsets and the ctrl reset value live here
`default_nettype none
package tbu_pkg;
  // command word A and B fields
  localparam int CMDA_OFS_LO = 16;   // start offset, five bits
  localparam int CMDA_OFS_W  = 5;
  localparam int CMDA_AL_LO  = 24;   // end alignment code, two bits
  localparam int CMDA_FS_BIT = 13;   // first segment
  localparam int CMDA_LS_BIT = 12;   // last segment
  localparam int SIZE_W      = 11;   // byte size / length field 10:0
  localparam int CMDB_TAG_LO = 16;   // packet tag 31:16
  // end alignment codes
  localparam logic [1:0] AL_4  = 2'h0;
  localparam logic [1:0] AL_16 = 2'h1;
  localparam logic [1:0] AL_32 = 2'h2;
  // status word bit positions
  localparam int ST_ES    = 15;
  localparam int ST_TAG   = 16;
  // register byte offsets and control bits
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_INFO = 12'h008;
  localparam int CTRL_SAO    = 0;    // status_overrun_allow
  localparam int CTRL_DEFCHK = 1;    // deferral checking enable
  localparam int INFO_OVR    = 8;
  localparam int INFO_TXE    = 31;   // transmit_error_flag, w1c
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int STAT_DEPTH  = 16;
  // per packet result from the mac transmitter
  typedef struct packed {
    logic       loss_carrier;
    logic       no_carrier;
    logic       late_col;
    logic       exc_col;
    logic [3:0] col_cnt;
    logic       exc_defer;
    logic       deferred;
  } tbu_res_s;
  // one byte toward the mac side fifo
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } tbu_byte_s;
  typedef enum logic [2:0] {
    S_CMDA, S_CMDB, S_SKIP, S_DATA, S_PAD
  } tbu_state_e;
endpackage
`default_nettype wire

// file: src/tbu_unpack.sv
// Purpose: unpack host tx buffers into a byte stream, return status
// Assumes: host words and mac results come from logic on pclk
// Notes:   one byte per cycle toward the mac; apb answers with no wait state
//
// Local design decisions: the register addresses and the APB slave port.
`default_nettype none
module tbu_unpack #(
  parameter int SDEPTH = tbu_pkg::STAT_DEPTH  // status fifo depth
) (
  input  wire  logic              pclk,
  input  wire  logic              presetn,
  input  wire  logic              ce,
  input  wire  logic              psel,
  input  wire  logic              penable,
  input  wire  logic              pwrite,
  input  wire  logic [11:0]       paddr,
  input  wire  logic [31:0]       pwdata,
  output var   logic [31:0]       prdata,
  output var   logic              pready,
  output var   logic              pslverr,
  input  wire  logic              hw_valid,
  input  wire  logic [31:0]       hw_data,
  output var   logic              hw_ready,
  output var   logic              mtx_valid,
  output var   tbu_pkg::tbu_byte_s mtx_byte,
  input  wire  logic              mtx_ready,
  input  wire  logic              res_valid,
  input  wire  tbu_pkg::tbu_res_s res,
  output var   logic              transmit_error_flag
);
  import tbu_pkg::*;
  localparam int AW = $clog2(SDEPTH);

  ////////////////////////////////////////////////////////////////////
  // state
  tbu_state_e           st_r;        // parser state
  logic [CMDA_OFS_W-1:0] ofs_r;      // start offset of buffer
  logic [1:0]           al_r;        // end alignment code
  logic                 ls_r;        // buffer closes the packet
  logic [SIZE_W-1:0]    rem_r;       // payload bytes left in buffer
  logic [SIZE_W-1:0]    len_r;       // packet length from command b
  logic [15:0]          tag_r;       // tag of open packet
  logic [15:0]          tag_done_r;  // tag of last closed packet
  logic [11:0]          pkt_bytes_r; // bytes forwarded this packet
  logic [2:0]           skip_r;      // whole offset words left
  logic [2:0]           wcnt_r;      // data section words, mod 8
  logic [31:0]          word_r;      // data word being unpacked
  logic                 have_r;      // word_r holds unsent bytes
  logic                 first_r;     // next data word is the first
  logic [1:0]           lane_r;      // byte lane to send next
  logic                 sao_r;       // status_overrun_allow
  logic                 defchk_r;    // deferral checking enable
  logic                 ovr_r;       // status fifo overran
  logic [31:0]          sfifo [SDEPTH];
  logic [AW-1:0]        wp_r;
  logic [AW-1:0]        rp_r;
  logic [AW:0]          cnt_r;       // status_used_count
  logic                 pop_ok_r;    // head was valid at setup
  logic                 fs_r;        // buffer is a first segment

  // alignment mask in words, used by the pad check and its check
  function automatic logic [2:0] al_mask(input logic [1:0] code);
    case (code)
      AL_16:   al_mask = 3'h3;
      AL_32:   al_mask = 3'h7;
      default: al_mask = 3'h0;       // 4-byte and unused code
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // decode
  wire        take     = hw_valid && hw_ready;
  wire        sfull    = (cnt_r == (AW+1)'(SDEPTH));
  wire        stall    = sfull && !sao_r;
  wire        aligned  = (wcnt_r & al_mask(al_r)) == 3'h0;
  wire        emit     = (st_r == S_DATA) && have_r &&
                         (!mtx_valid || mtx_ready);
  wire        word_end = (lane_r == 2'h3) || (rem_r == 11'h1);
  wire        buf_end  = (st_r == S_PAD) && aligned;
  wire        len_err  = buf_end && ls_r &&
                         (pkt_bytes_r != {1'b0, len_r});
  wire [CMDA_OFS_W-1:0] c_ofs = hw_data[CMDA_OFS_LO +: CMDA_OFS_W];
  wire [SIZE_W-1:0]     c_sz  = hw_data[SIZE_W-1:0];
  wire        want     = (st_r == S_CMDA && !stall) ||
                         (st_r == S_CMDB) || (st_r == S_SKIP) ||
                         (st_r == S_DATA && !have_r) ||
                         (st_r == S_PAD && !aligned);
  // where a buffer goes once its offset words are behind it
  wire tbu_state_e after_ofs = (rem_r != '0) ? S_DATA : S_PAD;

  ////////////////////////////////////////////////////////////////////
  // status word; bits 14:12, 7 and 1 stay zero
  wire        exdef = res.exc_defer && defchk_r;
  wire        es    = res.loss_carrier | res.no_carrier |
                      res.late_col | res.exc_col | exdef;
  wire [31:0] sword = {tag_done_r, es, 3'h0,
                       res.loss_carrier, res.no_carrier,
                       res.late_col, res.exc_col, 1'b0,
                       res.col_cnt, exdef, 1'b0,
                       res.deferred};
  wire        ovr_ev = res_valid && sfull && sao_r;
  wire        push   = res_valid && !sfull && !ovr_r;
  wire        txe_ov = res_valid && sfull && !sao_r;

  ////////////////////////////////////////////////////////////////////
  // apb decode
  wire        setup  = psel && !penable;
  wire        acc    = psel && penable && pready;
  wire        a_ctrl = (paddr == A_CTRL);
  wire        a_stat = (paddr == A_STAT);
  wire        a_info = (paddr == A_INFO);
  wire        mapped = a_ctrl || a_stat || a_info;
  wire        pop    = acc && !pwrite && a_stat && pop_ok_r;
  wire        clr_txe = acc && pwrite && a_info && pwdata[INFO_TXE];
  wire [AW:0] used   = ovr_r ? '0 : cnt_r;
  wire [31:0] info_w = {transmit_error_flag, 22'h0, ovr_r, (8-AW-1)'(0), used};
  wire [31:0] rd_w   = a_ctrl ? {30'h0, defchk_r, sao_r} :
                       a_stat ? ((cnt_r != '0) ? sfifo[rp_r] : 32'h0) :
                       a_info ? info_w : 32'h0;

  ////////////////////////////////////////////////////////////////////
  // word parser: commands stripped, offset and pad words dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r    <= S_CMDA;
      ofs_r   <= '0;
      al_r    <= AL_4;
      ls_r    <= 1'b0;
      skip_r  <= 3'h0;
      wcnt_r  <= 3'h0;
      first_r <= 1'b0;
      fs_r    <= 1'b0;
    end else if (ce) begin
      case (st_r)
        S_CMDA: if (take) begin
          ofs_r <= c_ofs;
          fs_r  <= hw_data[CMDA_FS_BIT];
          al_r  <= hw_data[CMDA_AL_LO +: 2];
          ls_r  <= hw_data[CMDA_LS_BIT];
          st_r  <= S_CMDB;
        end
        S_CMDB: if (take) begin
          skip_r  <= ofs_r[4:2];
          wcnt_r  <= 3'h0;
          first_r <= 1'b1;
          st_r    <= (ofs_r[4:2] != 3'h0) ? S_SKIP : after_ofs;
        end
        S_SKIP: if (take) begin
          skip_r <= skip_r - 3'h1;
          wcnt_r <= wcnt_r + 3'h1;
          if (skip_r == 3'h1) begin
            st_r <= after_ofs;
          end
        end
        S_DATA: begin
          if (take) begin
            wcnt_r  <= wcnt_r + 3'h1;
            first_r <= 1'b0;
          end
          if (emit && rem_r == 11'h1) begin
            st_r <= S_PAD;
          end
        end
        S_PAD: begin
          if (take) begin
            wcnt_r <= wcnt_r + 3'h1;
          end else if (aligned) begin
            st_r <= S_CMDA;
          end
        end
        default: st_r <= S_CMDA;
      endcase
    end
  end

  // buffer size, packet length and tag; b only kept on first segment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_r       <= '0;
      len_r       <= '0;
      tag_r       <= 16'h0;
      tag_done_r  <= 16'h0;
      pkt_bytes_r <= 12'h0;
    end else if (ce) begin
      if (take && st_r == S_CMDA) begin
        rem_r <= c_sz;
      end else if (emit) begin
        rem_r <= rem_r - 11'h1;
      end
      // the first segment's b word opens a packet
      if (take && st_r == S_CMDB && fs_r) begin
        len_r       <= c_sz;
        tag_r       <= hw_data[CMDB_TAG_LO +: 16];
        pkt_bytes_r <= 12'h0;
      end else if (emit) begin
        pkt_bytes_r <= pkt_bytes_r + 12'h1;
      end
      if (buf_end && ls_r) begin
        tag_done_r <= tag_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // word holder and lane walker; leading partial bytes skipped by lane, trailing ones by the byte count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_r <= 32'h0;
      have_r <= 1'b0;
      lane_r <= 2'h0;
    end else if (ce) begin
      if (take && st_r == S_DATA) begin
        word_r <= hw_data;
        have_r <= 1'b1;
        lane_r <= first_r ? ofs_r[1:0] : 2'h0;
      end else if (emit) begin
        lane_r <= lane_r + 2'h1;
        if (word_end) begin
          have_r <= 1'b0;
        end
      end
    end
  end

  // host ready drops after each take so one word is taken per decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_ready <= 1'b0;
    end else if (ce) begin
      hw_ready <= want && !take;
    end
  end

  // byte toward the mac; held until the mac takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mtx_valid <= 1'b0;
      mtx_byte  <= '0;
    end else if (ce) begin
      if (emit) begin
        mtx_valid     <= 1'b1;
        mtx_byte.data <= word_r[{lane_r, 3'h0} +: 8];
        mtx_byte.last <= ls_r && (rem_r == 11'h1);
      end else if (mtx_ready) begin
        mtx_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status fifo; pushes dropped while an allowed overrun stands
  always_ff @(posedge pclk) begin
    if (ce && push) begin
      sfifo[wp_r] <= sword;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      ovr_r <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      // a read frees space, which ends the overrun; a new one wins
      if (ovr_ev) begin
        ovr_r <= 1'b1;
      end else if (pop) begin
        ovr_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers and apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
      pop_ok_r <= 1'b0;
      sao_r    <= CTRL_RST[CTRL_SAO];
      defchk_r <= CTRL_RST[CTRL_DEFCHK];
    end else if (ce) begin
      pready   <= setup;
      pslverr  <= setup && !mapped;
      prdata   <= setup ? rd_w : 32'h0;
      pop_ok_r <= setup && (cnt_r != '0);
      if (acc && pwrite && a_ctrl) begin
        sao_r    <= pwdata[CTRL_SAO];
        defchk_r <= pwdata[CTRL_DEFCHK];
      end
    end
  end

  // error flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_error_flag <= 1'b0;
    end else if (ce) begin
      if (len_err || txe_ov) begin
        transmit_error_flag <= 1'b1;
      end else if (clr_txe) begin
        transmit_error_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the offset sits still until the next command a, so no history needed
  property p_lane;
    ce && take && st_r == S_DATA && first_r |=> lane_r == ofs_r[1:0];
  endproperty
  a_lane: assert property (p_lane) else $error("bad first lane");
  property p_skip;
    ce && take && st_r == S_CMDB && ofs_r[4:2] != 3'h0 |=>
      st_r == S_SKIP && skip_r == ofs_r[4:2];
  endproperty
  a_skip: assert property (p_skip) else $error("no skip");
  property p_trail;
    emit |-> rem_r != '0 && (st_r == S_DATA);
  endproperty
  a_trail: assert property (p_trail) else $error("extra byte");
  property p_pad;
    ce && st_r == S_PAD && aligned |=> st_r == S_CMDA && !hw_ready;
  endproperty
  a_pad: assert property (p_pad) else $error("pad not done");
  property p_stall;
    ce && st_r == S_CMDA && stall |=> !(hw_ready && st_r == S_CMDA);
  endproperty
  a_stall: assert property (p_stall) else $error("no stall");
  property p_ovr;
    ce && ovr_r && !pop |=> cnt_r == $past(cnt_r) && used == '0;
  endproperty
  a_ovr: assert property (p_ovr) else $error("status in ovr");
  property p_sao;
    ce && res_valid && sfull && sao_r && !len_err && !transmit_error_flag |=> !transmit_error_flag;
  endproperty
  a_sao: assert property (p_sao) else $error("txe on sao");
  property p_es;
    push |-> sword[ST_ES] == (|{sword[11:8], sword[2:1]}) &&
             sword[14:12] == 3'h0 && !sword[7] && !sword[1];
  endproperty
  a_es: assert property (p_es) else $error("bad summary");
  property p_tag;
    ce && buf_end && ls_r |=> tag_done_r == $past(tag_r);
  endproperty
  a_tag: assert property (p_tag) else $error("tag lost");
  // the flag may only fall by a software clear one cycle after it rose
  property p_len;
    ce && len_err |=> transmit_error_flag ##1 (transmit_error_flag || $past(clr_txe));
  endproperty
  a_len: assert property (p_len) else $error("len err");
  c_last: cover property (mtx_valid && mtx_ready && mtx_byte.last);
  c_skip: cover property (st_r == S_SKIP ##[1:20] st_r == S_PAD);
  c_ovr:  cover property (ovr_ev);
  c_pop:  cover property (pop ##1 push);
endmodule
`default_nettype wire

// file: dv/tbu_host_model.sv
// Purpose: host model that offers tx buffer words
// Assumes: the bench queues whole buffers through put_buf
// Notes:   idle data toggles so a stale word never looks valid
`default_nettype none
module tbu_host_model (
  input  wire logic        pclk,
  input  wire logic        hw_ready,
  output var  logic        hw_valid,
  output var  logic [31:0] hw_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import tbu_pkg::*;
  logic [31:0] q[$];      // words not yet taken
  int          taken = 0; // words the block accepted
  initial begin
    hw_valid = 1'b0;
    hw_data  = 32'h0;
  end
  ////////////////////////////////////////
  // lay out one buffer: commands, skip, data, end fill
  task automatic put_buf(input logic [31:0] ca, cb,
                         input logic [7:0] d[$]);
    logic [7:0] s[$];
    int         n;
    int         u;
    s = d;
    for (int i = 0; i < int'(ca[CMDA_OFS_LO +: 2]); i++)
      s.push_front(8'($urandom));   // filler lanes ahead of data
    while (s.size() % 4 != 0)
      s.push_back(8'($urandom));    // partial word of end fill
    q.push_back(ca);
    q.push_back(cb);
    n = int'(ca[CMDA_OFS_LO+2 +: 3]);
    for (int i = 0; i < n; i++)
      q.push_back($urandom);        // whole words to be skipped
    for (int i = 0; i < s.size(); i += 4)
      q.push_back({s[i+3], s[i+2], s[i+1], s[i]});
    n += s.size() / 4;
    u = (ca[CMDA_AL_LO +: 2] == AL_4) ? 1 :
        (ca[CMDA_AL_LO +: 2] == AL_16) ? 4 : 8;
    while (n % u != 0) begin
      q.push_back($urandom);        // whole fill words
      n++;
    end
  endtask
  // offer the head word and hold it until taken
  always @(posedge pclk) begin
    if (hw_valid && hw_ready) begin
      void'(q.pop_front());
      taken++;
    end
    if (q.size() > 0) begin
      hw_valid <= 1'b1;
      hw_data  <= q[0];
    end else begin
      hw_valid <= 1'b0;
      hw_data  <= ~hw_data;         // released bus shows no old word
    end
  end
endmodule
`default_nettype wire

// file: dv/tbu_unpack_tb.sv
// Purpose: self-checking bench for the tx buffer unpacker
// Assumes: host model feeds words, bench is mac side and apb master
// Notes:   status fifo shrunk to four entries so full comes fast
`default_nettype none
module tbu_unpack_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tbu_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        hw_valid, hw_ready, mtx_valid, mtx_ready, res_valid, transmit_error_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, hw_data;
  tbu_byte_s   mtx_byte;
  tbu_res_s    res;
  logic [8:0]  exp_b[$];  // bytes due at the mac side
  logic [33:0] exp_a[$];  // apb answers: check data, slverr, data
  logic [31:0] st_q[$];   // status words due from the fifo
  logic [33:0] ea;        // apb answer being compared
  logic [8:0]  eb;        // byte being compared
  logic [15:0] tag;       // tag of the latest packet
  logic        defchk;    // deferral check as programmed
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          t0;
  tbu_unpack #(.SDEPTH(4)) tbu_unpack_inst (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .hw_valid, .hw_data, .hw_ready,
    .mtx_valid, .mtx_byte, .mtx_ready, .res_valid, .res, .transmit_error_flag
  );
  tbu_host_model tbu_host_model_inst (.pclk, .hw_ready, .hw_valid,
                                      .hw_data);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic cmp_word(input logic [32:0] got, input logic [32:0] want);
    tests_run++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH %0t word %h expected %h", $time, got, want);
    end
  endtask
  task automatic cmp_byte(input logic [8:0] got, input logic [8:0] want);
    tests_run++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH %0t byte %h expected %h", $time, got, want);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic fail_wait();
    n_mismatch++;
    $display("MISMATCH %0t wait ran out", $time);
    complete_run();
  endtask
  // setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [33:0] e);
    exp_a.push_back(e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        psel    <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    fail_wait();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {2'b10, d});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  // bounded wait until every queued byte and every host word has left;
  // end fill words trail the last byte, and the packet only closes
  // (tag, length check) once they are taken
  task automatic wait_drain();
    for (int i = 0; i < 4000; i++) begin
      if (exp_b.size() == 0 && tbu_host_model_inst.q.size() == 0)
        return;
      @(posedge pclk);
    end
    fail_wait();
  endtask
  // one packet of nb buffers; bad puts a wrong length in command b
  task automatic send_pkt(input int nb, input logic bad);
    logic [7:0]  d[$];
    logic [31:0] ca;
    logic [31:0] cb;
    int          sz[3];
    int          tot;
    tot = 0;
    for (int b = 0; b < nb; b++) begin
      sz[b] = (b > 0 && b < nb - 1) ? 4 + $urandom % 9 : 1 + $urandom % 12;
      tot += sz[b];
    end
    tag = tag + 16'h1;
    cb = {tag, 5'h0, SIZE_W'(bad ? tot + 1 : tot)};
    for (int b = 0; b < nb; b++) begin
      ca = {6'h0, 2'((b + tag) % 3), 3'h0, 5'($urandom), 2'h0,
            b == 0, b == nb - 1, 1'b0, SIZE_W'(sz[b])};
      d.delete();
      for (int j = 0; j < sz[b]; j++) begin
        d.push_back(8'($urandom));
        exp_b.push_back({d[j], b == nb - 1 && j == sz[b] - 1});
      end
      tbu_host_model_inst.put_buf(ca, cb, d);
    end
  endtask
  // one-cycle mac result; keep notes the status it should give
  task automatic send_res(input logic keep);
    tbu_res_s r;
    logic     ed;
    r = tbu_res_s'(10'($urandom));
    ed = r.exc_defer & defchk;
    if (keep)
      st_q.push_back({tag, |{r.loss_carrier, r.no_carrier, r.late_col,
        r.exc_col, ed}, 3'h0, r.loss_carrier, r.no_carrier, r.late_col,
        r.exc_col, 1'b0, r.col_cnt, ed, 1'b0, r.deferred});
    @(posedge pclk);
    res_valid <= 1'b1;
    res       <= r;
    @(posedge pclk);
    res_valid <= 1'b0;
  endtask
  task automatic fill();
    repeat (4) begin
      send_pkt(1, 1'b0);
      wait_drain();
      send_res(1'b1);
    end
  endtask
  ////////////////////////////////////////
  // mac side stalls at random
  always @(posedge pclk)
    mtx_ready <= ($urandom % 4) != 0;
  // each answer is checked against the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      ea = (exp_a.size() > 0) ? exp_a.pop_front() : 34'h3_ffff_ffff;
      cmp_word({pslverr, ea[33] ? prdata : 32'h0}, ea[32:0]);
    end
    if (mtx_valid === 1'b1 && mtx_ready === 1'b1) begin
      eb = (exp_b.size() > 0) ? exp_b.pop_front() : ~mtx_byte;
      cmp_byte(mtx_byte, eb);
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    mtx_ready = 1'b0;
    res_valid = 1'b0;
    res = '0;
    presetn = 1'b0;
    tag = 16'h0;
    defchk = 1'b0;
    void'($urandom(2));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTRL, {30'h0, CTRL_RST});
    rd(A_INFO, 32'h0);
    apb(1'b0, 12'h00c, 32'h0, 34'h3_0000_0000);  // unmapped place
    for (int k = 0; k < 6; k++) begin
      defchk = k >= 3;
      wr(A_CTRL, {30'h0, defchk, 1'b0});
      send_pkt(k % 3 + 1, 1'b0);
      wait_drain();
      send_res(1'b1);
      rd(A_INFO, 32'h1);
      rd(A_STAT, st_q.pop_front());
    end
    // wrong length raises the error flag until cleared
    send_pkt(2, 1'b1);
    wait_drain();
    send_res(1'b1);
    rd(A_INFO, 32'h8000_0001);
    cmp_word({32'h0, transmit_error_flag}, 33'h1);
    wr(A_INFO, 32'h8000_0000);
    rd(A_STAT, st_q.pop_front());
    rd(A_INFO, 32'h0);
    // a full status fifo holds the next packet back
    wr(A_CTRL, 32'h0);
    defchk = 1'b0;
    fill();
    rd(A_INFO, 32'h4);
    t0 = tbu_host_model_inst.taken;
    send_pkt(1, 1'b0);
    repeat (40) @(posedge pclk);
    cmp_word(33'(tbu_host_model_inst.taken - t0), 33'h0);
    rd(A_STAT, st_q.pop_front());
    wait_drain();
    send_res(1'b1);
    repeat (4) rd(A_STAT, st_q.pop_front());
    // overrun allowed: sending goes on, the status is dropped
    wr(A_CTRL, 32'h1);
    fill();
    send_pkt(1, 1'b0);
    wait_drain();
    send_res(1'b0);
    rd(A_INFO, 32'h100);
    repeat (4) rd(A_STAT, st_q.pop_front());
    complete_run();
  end
endmodule
`default_nettype wire
